// >>> core/pllcs_pkg.sv
`default_nettype none
// ============================================================
// shared constants and types of the clock synthesis block
package pllcs_pkg;
	// ============================================================
	// structure
	localparam int NUM_LOOPS = 4;
	localparam int LINK_LOOPS = 2;
	// ============================================================
	// legal ranges: m and k share one range, n and v the other
	localparam logic [7:0] MK_MIN = 8'h02;
	localparam logic [7:0] MK_MAX = 8'ha0;
	localparam logic [4:0] NV_MIN = 5'h01;
	localparam logic [4:0] NV_MAX = 5'h10;
	// ============================================================
	// register map (byte addresses), loop i sits at i * LOOP_STRIDE
	localparam logic [7:0] LOOP_STRIDE = 8'h10;
	localparam logic [7:0] OFF_CFG = 8'h00;
	localparam logic [7:0] OFF_CTL = 8'h04;
	localparam logic [7:0] OFF_STAT = 8'h08;
	localparam logic [7:0] OFF_PAIR = 8'h40;
	// status bit positions
	localparam int STAT_LOCK_BIT = 0;
	localparam int STAT_VALID_BIT = 1;
	localparam int STAT_CONFL_BIT = 2;
	// ============================================================
	// reset values: all zero, which is an illegal ratio, so gated
	localparam logic [31:0] CFG_RST = 32'h0000_0000;
	localparam logic [31:0] CTL_RST = 32'h0000_0000;
	localparam logic [31:0] PAIR_RST = 32'h0000_0000;
	// ============================================================
	// timing
	localparam int LOCK_TIME_US = 10;
	localparam int MCLK_KHZ = 10000;
	// longest time, so rounded down
	localparam int LOCK_CYC = LOCK_TIME_US * MCLK_KHZ / 1000;
	// quarter ticks per generated period, gives the 90 degree grain
	localparam logic [3:0] QUARTERS = 4'h4;
	// ============================================================
	// types
	typedef enum logic [1:0] {BOOST_X1, BOOST_X2, BOOST_X4} pllcs_boost_e;
	typedef enum logic [1:0] {LK_IDLE, LK_ACQ, LK_LOCKED} pllcs_lock_e;
	typedef struct packed {
		logic [2:0] rsv_b;
		logic [4:0] v;
		logic [2:0] rsv_a;
		logic [4:0] n;
		logic [7:0] k;
		logic [7:0] m;
	} pllcs_cfg_s;
	typedef struct packed {
		logic [19:0] rsv;
		logic [3:0] delay;
		logic fb_ext;
		logic clkout_en;
		logic lock_en;
		logic [1:0] phase;
		logic src;
		logic sel_v;
		logic en;
	} pllcs_ctl_s;
	typedef struct packed {
		logic [27:0] rsv;
		logic [1:0] f2;
		logic [1:0] f1;
	} pllcs_pair_s;
endpackage
`default_nettype wire

// >>> core/pllcs_gen.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// ratio generator: quarter-tick accumulator, phase and delay
module pllcs_gen (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic run,
	input wire logic ref_edge,
	input wire logic [11:0] inc,
	input wire logic [12:0] modulus,
	input wire logic [1:0] phase,
	input wire logic [3:0] delay,
	output logic gclk_q
);
	logic [15:0] acc_q;
	logic [16:0] acc_sum;
	logic tick;
	logic [1:0] quad_q;
	logic [1:0] qph;
	logic [15:0] line_q;
	logic [3:0] cnt_q;
	logic [3:0] per_q;
	logic [3:0] eff;
	logic raw_prev_q;

	// each ref edge adds inc, each quarter tick drains modulus
	assign tick = run && (acc_q >= {3'h0, modulus});
	assign acc_sum = {1'b0, acc_q} + (ref_edge ? {5'h00, inc} : 17'h0_0000)
		- (tick ? {4'h0, modulus} : 17'h0_0000);
	assign qph = quad_q + phase;
	// delay never exceeds one measured period
	assign eff = (delay > per_q) ? per_q : delay;

	// accumulator saturates rather than wrap on a too-fast ref
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			acc_q <= 16'h0000;
		end else if (!run) begin
			acc_q <= 16'h0000;
		end else begin
			acc_q <= acc_sum[16] ? 16'hffff : acc_sum[15:0];
		end
	end

	// quarter counter, four ticks make one generated period
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			quad_q <= 2'h0;
		end else if (!run) begin
			quad_q <= 2'h0;
		end else if (tick) begin
			quad_q <= quad_q + 2'h1;
		end
	end

	// period measure in mclk cycles, saturating
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= 4'h0;
			per_q <= 4'h0;
			raw_prev_q <= 1'b0;
		end else begin
			raw_prev_q <= qph[1];
			if (qph[1] && !raw_prev_q) begin
				per_q <= cnt_q;
				cnt_q <= 4'h0;
			end else if (cnt_q != 4'hf) begin
				cnt_q <= cnt_q + 4'h1;
			end
		end
	end

	// delay line and gated output
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			line_q <= 16'h0000;
			gclk_q <= 1'b0;
		end else begin
			line_q <= {line_q[14:0], qph[1]};
			gclk_q <= run ? line_q[eff] : 1'b0;
		end
	end

	a_gen_gated: assert property (@(posedge mclk) disable iff (!nrst)
		!run |=> !gclk_q) else $error("generated clock not gated");
	a_quad_step: assert property (@(posedge mclk) disable iff (!nrst)
		run && tick && $past(run) |=> quad_q == $past(quad_q) + 2'h1)
		else $error("quarter step lost");
	c_gen_toggle: cover property (@(posedge mclk) disable iff (!nrst)
		$rose(gclk_q));
endmodule // pllcs_gen
`default_nettype wire

// >>> core/pllcs_lock.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// lock detector: counts acquisition time once the loop runs
module pllcs_lock (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic run,
	input wire logic ref_edge,
	input wire logic fb_edge,
	output logic locked_q
);
	pllcs_pkg::pllcs_lock_e st_q;
	logic [7:0] cnt_q;
	logic ref_seen_q;
	logic fb_seen_q;

	// state walk; dropping run restarts acquisition
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_q <= pllcs_pkg::LK_IDLE;
			cnt_q <= 8'h00;
			ref_seen_q <= 1'b0;
			fb_seen_q <= 1'b0;
		end else if (!run) begin
			st_q <= pllcs_pkg::LK_IDLE;
			cnt_q <= 8'h00;
			ref_seen_q <= 1'b0;
			fb_seen_q <= 1'b0;
		end else begin
			case (st_q)
				pllcs_pkg::LK_IDLE: begin
					st_q <= pllcs_pkg::LK_ACQ;
				end
				pllcs_pkg::LK_ACQ: begin
					ref_seen_q <= ref_seen_q | ref_edge;
					fb_seen_q <= fb_seen_q | fb_edge;
					if (cnt_q != 8'hff) begin
						cnt_q <= cnt_q + 8'h01;
					end
					// lock needs both edges, and no earlier than the bound
					if (cnt_q >= 8'(pllcs_pkg::LOCK_CYC - 2) &&
						(ref_seen_q | ref_edge) && (fb_seen_q | fb_edge)) begin
						st_q <= pllcs_pkg::LK_LOCKED;
					end
				end
				pllcs_pkg::LK_LOCKED: begin
					st_q <= pllcs_pkg::LK_LOCKED;
				end
				default: begin
					st_q <= pllcs_pkg::LK_IDLE;
				end
			endcase
		end
	end

	// indicator is a flop of the locked state
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			locked_q <= 1'b0;
		end else begin
			locked_q <= run && (st_q == pllcs_pkg::LK_LOCKED);
		end
	end

	a_lock_low: assert property (@(posedge mclk) disable iff (!nrst)
		!run |=> !locked_q) else $error("lock high while idle");
	a_lock_early: assert property (@(posedge mclk) disable iff (!nrst)
		$rose(locked_q) |-> cnt_q >= 8'(pllcs_pkg::LOCK_CYC - 1))
		else $error("lock came too early");
	c_lock_seen: cover property (@(posedge mclk) disable iff (!nrst)
		$rose(locked_q));
endmodule // pllcs_lock
`default_nettype wire

// >>> core/pllcs_top.sv
`timescale 1ns/1ps
`default_nettype none
module pllcs_top (
	input wire logic mclk,
	input wire logic nrst,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// configuration finished strobe level
	input wire logic cfg_done,
	// dedicated clock inputs, index 0 first, index 1 second
	input wire logic first_dedicated_clock_input,
	input wire logic second_dedicated_clock_input,
	// external feedback returns
	input wire logic [3:0] fb_in,
	// user drive for lock pins when indicators are off
	input wire logic [3:0] user_o,
	input wire logic [3:0] user_oe,
	// generated clocks, internal and off chip
	output logic [3:0] gclk,
	output logic [3:0] clk_out_o,
	output logic [3:0] clk_out_oe,
	output logic [3:0] lock_pin_o,
	output logic [3:0] lock_pin_oe
);
	localparam int NL = pllcs_pkg::NUM_LOOPS;

	// ============================================================
	// bus slave
	logic wr_pend_q;
	logic [7:0] addr_q;
	logic [31:0] hrdata_q;
	logic hreadyout_q;
	logic hresp_q;
	logic [31:0] rd_d;
	logic take;
	logic [NL-1:0] locked;
	logic [NL-1:0] valid;
	logic [NL-1:0] gclk_w;
	logic cfg_done_q;
	logic conflict;
	logic pair_ok;
	pllcs_pkg::pllcs_cfg_s cfg_q [NL];
	pllcs_pkg::pllcs_ctl_s ctl_q [NL];
	pllcs_pkg::pllcs_pair_s pair_q;

	assign take = hsel && hready && htrans[1];

	// address phase capture; zero wait states, always okay
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wr_pend_q <= 1'b0;
			addr_q <= 8'h00;
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
		end else begin
			wr_pend_q <= take && hwrite;
			if (take) begin
				addr_q <= haddr[7:0];
			end
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
		end
	end

	// read mux, evaluated in the address phase; unmapped reads zero
	always_comb begin
		rd_d = 32'h0000_0000;
		for (int i = 0; i < NL; i++) begin
			if (haddr[7:0] == 8'(i * 16) + pllcs_pkg::OFF_CFG) begin
				rd_d = cfg_q[i];
			end
			if (haddr[7:0] == 8'(i * 16) + pllcs_pkg::OFF_CTL) begin
				rd_d = ctl_q[i];
			end
			if (haddr[7:0] == 8'(i * 16) + pllcs_pkg::OFF_STAT) begin
				rd_d[pllcs_pkg::STAT_LOCK_BIT] = locked[i];
				rd_d[pllcs_pkg::STAT_VALID_BIT] = valid[i];
				rd_d[pllcs_pkg::STAT_CONFL_BIT] = conflict;
			end
		end
		if (haddr[7:0] == pllcs_pkg::OFF_PAIR) begin
			rd_d = pair_q;
		end
	end

	// read data held in a flop so the data phase sees a stable word
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			hrdata_q <= 32'h0000_0000;
		end else if (take && !hwrite) begin
			hrdata_q <= rd_d;
		end
	end

	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;

	// ============================================================
	// shared pair register for the factor pairing
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pair_q <= pllcs_pkg::PAIR_RST;
		end else if (wr_pend_q && addr_q == pllcs_pkg::OFF_PAIR) begin
			pair_q <= {28'h000_0000, hwdata[3:0]};
		end
	end

	// clock one factor may not exceed clock two, x4 is the top code
	assign pair_ok = (pair_q.f2 <= 2'(pllcs_pkg::BOOST_X4)) &&
		(pair_q.f1 <= pair_q.f2);

	// both lower loops on the second input shuts out the first input
	assign conflict = ctl_q[0].en && ctl_q[0].src &&
		ctl_q[1].en && ctl_q[1].src;

	// configuration done is a level; nothing runs before it
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cfg_done_q <= 1'b0;
		end else begin
			cfg_done_q <= cfg_done;
		end
	end

	// ============================================================
	// reference edge detection, inputs are synchronous to mclk
	logic [1:0] ref_q;
	logic [1:0] ref_prev_q;
	logic [1:0] ref_edge;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ref_q <= 2'h0;
			ref_prev_q <= 2'h0;
		end else begin
			ref_q <= {second_dedicated_clock_input,
				first_dedicated_clock_input};
			ref_prev_q <= ref_q;
		end
	end

	assign ref_edge = ref_q & ~ref_prev_q;

	// ============================================================
	// one slice per loop; loops share only the pair register and the input conflict
	for (genvar g = 0; g < NL; g++) begin : g_loop
		logic wr_cfg;
		logic wr_ctl;
		logic restart_q;
		logic range_ok;
		logic run;
		logic my_ref;
		logic [1:0] boost;
		logic [11:0] inc;
		logic [12:0] modulus;
		logic [7:0] post_div;
		logic fb_prev_q;
		logic int_prev_q;
		logic fb_edge;
		logic clk_o_q;
		logic clk_oe_q;
		logic lk_o_q;
		logic lk_oe_q;

		assign wr_cfg = wr_pend_q &&
			addr_q == 8'(g * 16) + pllcs_pkg::OFF_CFG;
		assign wr_ctl = wr_pend_q &&
			addr_q == 8'(g * 16) + pllcs_pkg::OFF_CTL;

		// reserved fields are dropped on write so they read zero
		always_ff @(posedge mclk or negedge nrst) begin
			if (!nrst) begin
				cfg_q[g] <= pllcs_pkg::CFG_RST;
				ctl_q[g] <= pllcs_pkg::CTL_RST;
			end else begin
				if (wr_cfg) begin
					cfg_q[g] <= hwdata & 32'h1f1f_ffff;
				end
				if (wr_ctl) begin
					ctl_q[g] <= hwdata & 32'h0000_0fff;
				end
			end
		end

		// any rewrite drops the loop for a cycle so lock re-acquires
		always_ff @(posedge mclk or negedge nrst) begin
			if (!nrst) begin
				restart_q <= 1'b0;
			end else begin
				restart_q <= wr_cfg || wr_ctl;
			end
		end

		// post-scaler is k or v, whichever the control word selects
		assign post_div = ctl_q[g].sel_v ? {3'h0, cfg_q[g].v} : cfg_q[g].k;
		// range check on m, n and whichever post-scaler is chosen
		assign range_ok = cfg_q[g].m >= pllcs_pkg::MK_MIN &&
			cfg_q[g].m <= pllcs_pkg::MK_MAX &&
			cfg_q[g].n >= pllcs_pkg::NV_MIN &&
			cfg_q[g].n <= pllcs_pkg::NV_MAX &&
			(ctl_q[g].sel_v ? (cfg_q[g].v >= pllcs_pkg::NV_MIN &&
				cfg_q[g].v <= pllcs_pkg::NV_MAX) :
			(cfg_q[g].k >= pllcs_pkg::MK_MIN &&
				cfg_q[g].k <= pllcs_pkg::MK_MAX));

		// the two lower loops carry the pairing and the boost factor
		if (g < pllcs_pkg::LINK_LOOPS) begin : g_pair
			assign boost = (g == 0) ? pair_q.f1 : pair_q.f2;
			assign valid[g] = range_ok && pair_ok &&
				!(conflict && !ctl_q[g].src);
		end else begin : g_plain
			assign boost = 2'(pllcs_pkg::BOOST_X1);
			assign valid[g] = range_ok && !(conflict && !ctl_q[g].src);
		end

		assign run = cfg_done_q && ctl_q[g].en && valid[g] && !restart_q;
		assign my_ref = ctl_q[g].src ? ref_edge[1] : ref_edge[0];

		// quarter ticks per ref edge; boost multiplies the slow clock
		assign inc = 12'({cfg_q[g].m, 2'h0} << boost);
		assign modulus = 13'(cfg_q[g].n *
			post_div);

		pllcs_gen u_gen (
			.mclk(mclk),
			.nrst(nrst),
			.run(run),
			.ref_edge(my_ref),
			.inc(inc),
			.modulus(modulus),
			.phase(ctl_q[g].phase),
			.delay(ctl_q[g].delay),
			.gclk_q(gclk_w[g])
		);

		// feedback is the own output, or the returned off-chip copy
		always_ff @(posedge mclk or negedge nrst) begin
			if (!nrst) begin
				fb_prev_q <= 1'b0;
				int_prev_q <= 1'b0;
			end else begin
				fb_prev_q <= fb_in[g];
				int_prev_q <= gclk_w[g];
			end
		end

		assign fb_edge = ctl_q[g].fb_ext ? (fb_in[g] && !fb_prev_q) :
			(gclk_w[g] && !int_prev_q);

		pllcs_lock u_lock (
			.mclk(mclk),
			.nrst(nrst),
			.run(run),
			.ref_edge(my_ref),
			.fb_edge(fb_edge),
			.locked_q(locked[g])
		);

		// pin stage: off-chip clock and shared lock or user pin
		always_ff @(posedge mclk or negedge nrst) begin
			if (!nrst) begin
				clk_o_q <= 1'b0;
				clk_oe_q <= 1'b0;
				lk_o_q <= 1'b0;
				lk_oe_q <= 1'b0;
			end else begin
				clk_o_q <= ctl_q[g].clkout_en && gclk_w[g];
				clk_oe_q <= ctl_q[g].clkout_en;
				lk_o_q <= ctl_q[g].lock_en ? locked[g] : user_o[g];
				lk_oe_q <= ctl_q[g].lock_en ? 1'b1 : user_oe[g];
			end
		end

		assign clk_out_o[g] = clk_o_q;
		assign clk_out_oe[g] = clk_oe_q;
		assign lock_pin_o[g] = lk_o_q;
		assign lock_pin_oe[g] = lk_oe_q;
		assign gclk[g] = gclk_w[g];

		a_lock_user: assert property (@(posedge mclk) disable iff (!nrst)
			!ctl_q[g].lock_en |=> lock_pin_o[g] == $past(user_o[g]) &&
			lock_pin_oe[g] == $past(user_oe[g]))
			else $error("user pin not passed");
		a_lock_pin: assert property (@(posedge mclk) disable iff (!nrst)
			ctl_q[g].lock_en && $stable(ctl_q[g]) |=> lock_pin_oe[g] &&
			lock_pin_o[g] == $past(locked[g]))
			else $error("lock pin wrong");
		a_range_gate: assert property (@(posedge mclk) disable iff (!nrst)
			!range_ok |-> ##2 !gclk_w[g] && !locked[g])
			else $error("bad ratio not gated");
		a_cfg_wait: assert property (@(posedge mclk) disable iff (!nrst)
			!cfg_done_q ##1 !cfg_done_q |-> !locked[g])
			else $error("lock before config done");
		a_rewrite_drop: assert property (@(posedge mclk) disable iff (!nrst)
			wr_cfg |-> ##2 !locked[g])
			else $error("lock kept over rewrite");
	end

	a_pair_reject: assert property (@(posedge mclk) disable iff (!nrst)
		!pair_ok |-> !valid[0] && !valid[1])
		else $error("illegal pairing accepted");
	a_src_shared: assert property (@(posedge mclk) disable iff (!nrst)
		conflict && ctl_q[2].en && !ctl_q[2].src |-> !valid[2])
		else $error("first input used in shared mode");
	a_resp_okay: assert property (@(posedge mclk) disable iff (!nrst)
		take |=> hreadyout && !hresp)
		else $error("slave did not answer okay");
	c_bus_write: cover property (@(posedge mclk) disable iff (!nrst)
		take && hwrite ##1 wr_pend_q);
	c_all_locked: cover property (@(posedge mclk) disable iff (!nrst)
		&locked);
	c_shared_src: cover property (@(posedge mclk) disable iff (!nrst)
		conflict && valid[0] && valid[1]);
endmodule // pllcs_top
`default_nettype wire

// >>> tb/pllcs_board.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// board side: reference oscillators and an externally clocked device
module pllcs_board #(
	parameter int HALF = 20
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [1:0] osc_en,
	input wire logic [3:0] clk_out_o,
	input wire logic [3:0] clk_out_oe,
	output logic ref_a,
	output logic ref_b,
	output logic [3:0] fb_in
);
	int cnt_q;
	// oscillators stand low while off, so no stray edge reaches a loop;
	// kept far slower than mclk since the loops sample them as data
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= 0;
			ref_a <= 1'b0;
			ref_b <= 1'b0;
		end else begin
			cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
			if (cnt_q == HALF - 1) begin
				ref_a <= osc_en[0] & ~ref_a;
				ref_b <= osc_en[1] & ~ref_b;
			end
		end
	end
	// far device echoes the forwarded clock a cycle late; an undriven
	// pad reads low through its pull-down
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			fb_in <= 4'h0;
		end else begin
			fb_in <= clk_out_o & clk_out_oe;
		end
	end
endmodule // pllcs_board
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int REF_HALF = 20;
	logic mclk, nrst, hsel, hwrite, cfg_done, hreadyout, hresp, ref_a, ref_b;
	logic [1:0] htrans, osc_en;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata;
	logic [3:0] fb_in, user_o, user_oe, gclk, clk_out_o, clk_out_oe;
	logic [3:0] lock_pin_o, lock_pin_oe;
	int fails = 0;
	int check_count = 0;
	// ============================================================
	// design and board
	pllcs_top DUT (.mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .cfg_done(cfg_done),
		.first_dedicated_clock_input(ref_a),
		.second_dedicated_clock_input(ref_b), .fb_in(fb_in),
		.user_o(user_o), .user_oe(user_oe), .gclk(gclk),
		.clk_out_o(clk_out_o), .clk_out_oe(clk_out_oe),
		.lock_pin_o(lock_pin_o), .lock_pin_oe(lock_pin_oe));
	pllcs_board #(.HALF(REF_HALF)) board (.mclk(mclk), .nrst(nrst),
		.osc_en(osc_en), .clk_out_o(clk_out_o), .clk_out_oe(clk_out_oe),
		.ref_a(ref_a), .ref_b(ref_b), .fb_in(fb_in));
	// 10 MHz system clock
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// ============================================================
	// comparison, report and bus tasks
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// bounded wait: a stuck slave must not hang the run
	task automatic wait_ready;
		int i;
		i = 0;
		do begin
			@(posedge mclk);
			i++;
		end while (hreadyout !== 1'b1 && i < 50);
		if (hreadyout !== 1'b1) begin
			fails++;
			end_of_test();
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rdat);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'b10;
		hwrite <= w;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_ready();
		rdat = hrdata;
		check("okay response", 32'(hresp), 0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		bus(1'b0, a, 32'h0000_0000, d);
	endtask
	function automatic logic [7:0] ra(input int lp, input logic [7:0] off);
		return 8'(lp) * pllcs_pkg::LOOP_STRIDE + off;
	endfunction
	// gclk is a flop on mclk, so sampling each edge sees every pulse
	task automatic cnt_rise(input int lp, input int n, output int c);
		logic last;
		c = 0;
		last = gclk[lp];
		repeat (n) begin
			@(posedge mclk);
			if (gclk[lp] === 1'b1 && last === 1'b0) c++;
			last = gclk[lp];
		end
	endtask
	// ============================================================
	// scenarios
	task automatic t_regs;
		logic [31:0] d;
		rd(ra(0, pllcs_pkg::OFF_CFG), d);
		check("cfg reset", d, pllcs_pkg::CFG_RST);
		rd(ra(1, pllcs_pkg::OFF_CTL), d);
		check("ctl reset", d, pllcs_pkg::CTL_RST);
		rd(pllcs_pkg::OFF_PAIR, d);
		check("pair reset", d, pllcs_pkg::PAIR_RST);
		wr(ra(3, pllcs_pkg::OFF_CFG), 32'hffff_ffff);
		rd(ra(3, pllcs_pkg::OFF_CFG), d);
		check("cfg fields", d, 32'h1f1f_ffff);
		wr(ra(3, pllcs_pkg::OFF_CTL), 32'hffff_ffff);
		rd(ra(3, pllcs_pkg::OFF_CTL), d);
		check("ctl fields", d, 32'h0000_0fff);
		wr(ra(3, pllcs_pkg::OFF_CTL), 32'h0000_0000);
		wr(8'h80, 32'hffff_ffff);
		rd(8'h80, d);
		check("unmapped", d, 32'h0000_0000);
		wr(ra(0, pllcs_pkg::OFF_STAT), 32'hffff_ffff);
		rd(ra(0, pllcs_pkg::OFF_STAT), d);
		check("status read only", d, 32'h0000_0000);
		$display("register test done");
	endtask
	task automatic t_lock;
		int t;
		int c;
		logic [31:0] d;
		wr(ra(3, pllcs_pkg::OFF_CFG), 32'h0001_0204);
		wr(ra(3, pllcs_pkg::OFF_CTL), 32'h0000_00e1);
		cnt_rise(3, 150, c);
		check("gclk before config done", 32'(c), 0);
		rd(ra(3, pllcs_pkg::OFF_STAT), d);
		check("lock before config done", 32'(d[0]), 0);
		check("user pin data", 32'(lock_pin_o[2:0]), 32'(user_o[2:0]));
		check("user pin oe", 32'(lock_pin_oe[2:0]), 32'(user_oe[2:0]));
		cfg_done <= 1'b1;
		t = 0;
		while (lock_pin_o[3] !== 1'b1 && t < 300) begin
			@(posedge mclk);
			t++;
		end
		check("lock time", 32'(t <= 108), 1);
		if (t >= 300) end_of_test();
		rd(ra(3, pllcs_pkg::OFF_STAT), d);
		check("lock status", 32'(d[0]), 1);
		check("lock pin oe", 32'(lock_pin_oe[3]), 1);
		check("clock out oe", 32'(clk_out_oe[3]), 1);
		wr(ra(3, pllcs_pkg::OFF_CFG), 32'h0001_0204);
		repeat (5) @(posedge mclk);
		check("lock drops on rewrite", 32'(lock_pin_o[3]), 0);
		wr(ra(3, pllcs_pkg::OFF_CTL), 32'h0000_0000);
		$display("lock test done");
	endtask
	task automatic t_range;
		logic [31:0] tbl [8] = '{32'h0001_0202, 32'h0001_0201, 32'h0010_a0a0,
			32'h0001_02a1, 32'h0000_0202, 32'h0011_0202, 32'h0001_0102,
			32'h0001_a102};
		logic [31:0] d;
		logic ok;
		int c;
		for (int i = 0; i < 8; i++) begin
			ok = tbl[i][7:0] >= pllcs_pkg::MK_MIN
				&& tbl[i][7:0] <= pllcs_pkg::MK_MAX
				&& tbl[i][15:8] >= pllcs_pkg::MK_MIN
				&& tbl[i][15:8] <= pllcs_pkg::MK_MAX
				&& tbl[i][20:16] >= pllcs_pkg::NV_MIN
				&& tbl[i][20:16] <= pllcs_pkg::NV_MAX;
			wr(ra(2, pllcs_pkg::OFF_CFG), tbl[i]);
			wr(ra(2, pllcs_pkg::OFF_CTL), 32'h0000_0001);
			cnt_rise(2, 100, c);
			rd(ra(2, pllcs_pkg::OFF_STAT), d);
			check("range valid", 32'(d[1]), 32'(ok));
			if (!ok) check("gclk gated", 32'(c), 0);
		end
		wr(ra(2, pllcs_pkg::OFF_CTL), 32'h0000_0000);
		$display("range test done");
	endtask
	task automatic rate_case(input int lp, input logic [31:0] cfg,
		input logic [31:0] ctl, input logic [31:0] pair, input int exp);
		int c;
		wr(pllcs_pkg::OFF_PAIR, pair);
		wr(ra(lp, pllcs_pkg::OFF_CFG), cfg);
		wr(ra(lp, pllcs_pkg::OFF_CTL), ctl);
		repeat (60) @(posedge mclk);
		cnt_rise(lp, 800, c);
		check("generated rate", 32'(c >= exp - 2 && c <= exp + 2), 1);
		wr(ra(lp, pllcs_pkg::OFF_CTL), 32'h0000_0000);
		wr(pllcs_pkg::OFF_PAIR, 32'h0000_0000);
	endtask
	task automatic t_rate;
		int refs;
		refs = 800 / (2 * REF_HALF);
		rate_case(2, 32'h0001_0204, 32'h0000_0001, 0, refs * 4 / 2);
		rate_case(2, 32'h0401_0204, 32'h0000_0003, 0, refs * 4 / 4);
		rate_case(1, 32'h0001_0202, 32'h0000_0005, 32'h0000_0008, refs * 4);
		rate_case(0, 32'h0001_0202, 32'h0000_0001, 32'h0000_0005, refs * 2);
		$display("rate test done");
	endtask
	task automatic t_pair;
		logic [31:0] d;
		wr(ra(0, pllcs_pkg::OFF_CFG), 32'h0001_0202);
		wr(ra(0, pllcs_pkg::OFF_CTL), 32'h0000_0001);
		for (int p = 0; p < 16; p++) begin
			wr(pllcs_pkg::OFF_PAIR, 32'(p));
			rd(ra(0, pllcs_pkg::OFF_STAT), d);
			check("pairing", 32'(d[1]), 32'(p / 4 <= 2 && p % 4 <= p / 4));
		end
		wr(pllcs_pkg::OFF_PAIR, 32'h0000_0000);
		$display("pairing test done");
	endtask
	task automatic t_share;
		logic [31:0] d;
		// board leaves the first input still while both loops share
		osc_en <= 2'b10;
		wr(ra(1, pllcs_pkg::OFF_CFG), 32'h0001_0202);
		wr(ra(0, pllcs_pkg::OFF_CTL), 32'h0000_0005);
		wr(ra(1, pllcs_pkg::OFF_CTL), 32'h0000_0005);
		wr(ra(2, pllcs_pkg::OFF_CFG), 32'h0001_0202);
		wr(ra(2, pllcs_pkg::OFF_CTL), 32'h0000_0001);
		rd(ra(2, pllcs_pkg::OFF_STAT), d);
		check("first input refused", 32'(d[1]), 0);
		check("conflict flag", 32'(d[2]), 1);
		wr(ra(1, pllcs_pkg::OFF_CTL), 32'h0000_0000);
		rd(ra(2, pllcs_pkg::OFF_STAT), d);
		check("first input free", 32'(d[1]), 1);
		check("conflict clear", 32'(d[2]), 0);
		osc_en <= 2'b11;
		$display("shared input test done");
	endtask
	// at ratio one the four ticks of a reference edge drain on four
	// consecutive cycles, so one quarter period is one mclk cycle here
	task automatic shift_case(input logic [31:0] ctl, output int off);
		int n;
		logic last;
		wr(ra(2, pllcs_pkg::OFF_CFG), 32'h0001_0202);
		wr(ra(2, pllcs_pkg::OFF_CTL), ctl);
		repeat (60) @(posedge mclk);
		n = 0;
		last = 1'b1;
		while (!(ref_a === 1'b1 && last === 1'b0) && n < 100) begin
			last = ref_a;
			@(posedge mclk);
			n++;
		end
		off = 0;
		last = gclk[2];
		while (!(gclk[2] === 1'b1 && last === 1'b0) && off < 40) begin
			last = gclk[2];
			@(posedge mclk);
			off++;
		end
		if (n >= 100 || off >= 40) begin
			fails++;
			end_of_test();
		end
		wr(ra(2, pllcs_pkg::OFF_CTL), 32'h0000_0000);
	endtask
	task automatic t_shift;
		int base;
		int o;
		shift_case(32'h0000_0001, base);
		shift_case(32'h0000_0009, o);
		check("phase step", 32'(base - o), 1);
		shift_case(32'h0000_0201, o);
		check("delay shift", 32'(o - base), 2);
		$display("phase and delay test done");
	endtask
	// ============================================================
	// main sequence: inputs set at time zero, reset held 8 cycles
	initial begin
		nrst = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		cfg_done = 1'b0;
		user_o = 4'h5;
		user_oe = 4'hc;
		osc_en = 2'h3;
		repeat (8) @(posedge mclk);
		nrst <= 1'b1;
		t_regs();
		t_lock();
		t_range();
		t_rate();
		t_pair();
		t_share();
		t_shift();
		end_of_test();
	end
endmodule // testbench
`default_nettype wire
